//--- src/tcf_outputs.sv
// telecom clock and 8 khz frame pulse output stage
`timescale 1ns/1ps
module tcf_outputs #(
    parameter int FRAME_LEN = tcf_pkg::FRAME_CYCLES
) (
    input wire logic clock,
    input wire logic rstn,
    input wire logic ref_select,
    input wire logic [1:0] ref_a_freq_sel,
    input wire logic [1:0] ref_b_freq_sel,
    input wire logic reference_in_a,
    input wire logic reference_in_b,
    output logic selected_reference,
    output logic e1_clock_out,
    output logic t1_double_clock_out,
    output logic t1_clock_out,
    output logic ds2_clock_out,
    output logic follow_ref_clock_out,
    output logic backplane_clock_top,
    output logic backplane_clock_high,
    output logic optical_clock_out,
    output logic optical_frame_out,
    output logic frame_pulse_30ns_n,
    output logic frame_pulse_61ns_n,
    output logic frame_pulse_122ns,
    output logic frame_pulse_244ns_n,
    output logic receive_sync_pulse,
    output logic transmit_sync_pulse
);
    import tcf_pkg::*;

    ////////////////////////////////////////////////////////////////////////////
    // common frame counter
    logic [FCNT_W-1:0] frame_cnt_q;
    wire frame_last = (frame_cnt_q == FCNT_W'(FRAME_LEN - 1));

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            frame_cnt_q <= '0;
        end else if (frame_last) begin
            frame_cnt_q <= '0; // [R18]
        end else begin
            frame_cnt_q <= frame_cnt_q + FCNT_W'(1);
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // ncos; phase restarts each frame so clock edges line up with pulses
    // trade-off: edges jitter by one 5 ns cycle, average rate is exact
    logic [NCO_NUM-1:0] nco_clk;

    generate
        for (genvar i = 0; i < NCO_NUM; i++) begin : g_nco
            logic [NCO_W-1:0] acc_q;
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    acc_q <= '0;
                end else if (frame_last) begin
                    acc_q <= '0; // [R18]
                end else begin
                    acc_q <= acc_q + NCO_INC[i]; // [R1] [R2] [R3] [R4] [R14] [R15] [R16]
                end
            end
            assign nco_clk[i] = acc_q[NCO_W-1];
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // reference selection and follow clock rate
    wire [1:0] sel_freq = ref_select ? ref_b_freq_sel : ref_a_freq_sel; // [R17]
    wire sel_is_t1 = (sel_freq == REF_SEL_1M544);
    wire follow_d = sel_is_t1 ? nco_clk[NCO_T1] : nco_clk[NCO_E1]; // [R5] [R6]
    wire sel_ref_d = ref_select ? reference_in_b : reference_in_a; // [R17]

    ////////////////////////////////////////////////////////////////////////////
    // frame pulses, width one period of the matching clock
    logic [FP_NUM-1:0] fp_q;

    generate
        for (genvar j = 0; j < FP_NUM; j++) begin : g_fp
            wire active = (frame_cnt_q < FP_CYCLES[j]); // [R19]
            always_ff @(posedge clock or negedge rstn) begin
                if (!rstn) begin
                    fp_q[j] <= FP_ACT_LOW[j];
                end else begin
                    fp_q[j] <= active ^ FP_ACT_LOW[j]; // [R7] [R8] [R9] [R10] [R11] [R12]
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // registered clock outputs
    logic [NCO_NUM-1:0] clk_q;
    logic follow_q;
    logic sel_ref_q;

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            clk_q <= '0;
            follow_q <= 1'b0;
            sel_ref_q <= 1'b0;
        end else begin
            clk_q <= nco_clk;
            follow_q <= follow_d; // [R5] [R6]
            sel_ref_q <= sel_ref_d;
        end
    end

    assign e1_clock_out = clk_q[NCO_E1];
    assign t1_double_clock_out = clk_q[NCO_T1X2];
    assign t1_clock_out = clk_q[NCO_T1];
    assign ds2_clock_out = clk_q[NCO_DS2];
    assign backplane_clock_top = clk_q[NCO_BP_TOP];
    assign backplane_clock_high = clk_q[NCO_BP_HIGH];
    assign optical_clock_out = clk_q[NCO_OPT];
    assign follow_ref_clock_out = follow_q;
    assign selected_reference = sel_ref_q;

    // framers latch on the asserted edge as frame start
    assign optical_frame_out = fp_q[FP_OPT];
    assign frame_pulse_30ns_n = fp_q[FP_30];
    assign frame_pulse_61ns_n = fp_q[FP_61];
    assign frame_pulse_122ns = fp_q[FP_122]; // [R13]
    assign frame_pulse_244ns_n = fp_q[FP_244];
    assign receive_sync_pulse = fp_q[FP_RX];
    assign transmit_sync_pulse = fp_q[FP_TX];

endmodule

//--- shared/tcf_pkg.sv
// constants for the telecom clock and frame output stage
// Operation
// R1 - e1 clock output runs continuously at 2.048 MHz
// R2 - t1 double clock output at 3.088 MHz
// R3 - t1 clock output at 1.544 MHz
// R4 - ds2 clock output at 6.312 MHz
// R5 - follow clock 2.048 MHz for other references
// R6 - follow clock 1.544 MHz for 1.544 reference
// R7 - optical frame pulse one 19.44 MHz period
// R8 - active-low 30 ns frame pulse at 8 kHz
// R9 - active-low 61 ns frame pulse at 8 kHz
// R10 - active-high 122 ns frame pulse at 8 kHz
// R11 - active-low 244 ns frame pulse at 8 kHz
// R12 - receive and transmit sync 488 ns high
// R13 - framers treat asserted edge as frame start
// R14 - top backplane clock at 32.768 MHz
// R15 - high backplane clock at 16.384 MHz
// R16 - optical clock output at 19.44 MHz
// R17 - select input picks one reference only
// R18 - all frame pulses share one frame counter
// R19 - pulse width is one matching clock period
package tcf_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // system clock
    localparam longint CLK_HZ = 200_000_000;
    localparam int CLK_PERIOD_NS = 5;
    localparam longint FRAME_HZ = 8_000;
    localparam int FRAME_CYCLES = int'(CLK_HZ / FRAME_HZ);

    ////////////////////////////////////////////////////////////////////////////
    // generated clock rates in hz
    localparam longint E1_HZ = 2_048_000;
    localparam longint T1X2_HZ = 3_088_000;
    localparam longint T1_HZ = 1_544_000;
    localparam longint DS2_HZ = 6_312_000;
    localparam longint BP_TOP_HZ = 32_768_000;
    localparam longint BP_HIGH_HZ = 16_384_000;
    localparam longint OPT_HZ = 19_440_000;

    // nco channel indices
    localparam int NCO_E1 = 0;
    localparam int NCO_T1X2 = 1;
    localparam int NCO_T1 = 2;
    localparam int NCO_DS2 = 3;
    localparam int NCO_BP_TOP = 4;
    localparam int NCO_BP_HIGH = 5;
    localparam int NCO_OPT = 6;
    localparam int NCO_NUM = 7;
    localparam int NCO_W = 32;

    localparam logic [NCO_W-1:0] NCO_INC [NCO_NUM] = '{
        NCO_W'((E1_HZ << NCO_W) / CLK_HZ),
        NCO_W'((T1X2_HZ << NCO_W) / CLK_HZ),
        NCO_W'((T1_HZ << NCO_W) / CLK_HZ),
        NCO_W'((DS2_HZ << NCO_W) / CLK_HZ),
        NCO_W'((BP_TOP_HZ << NCO_W) / CLK_HZ),
        NCO_W'((BP_HIGH_HZ << NCO_W) / CLK_HZ),
        NCO_W'((OPT_HZ << NCO_W) / CLK_HZ)
    };

    ////////////////////////////////////////////////////////////////////////////
    // frame pulse widths, times not a multiple of 5 ns round down
    localparam int FP_30_NS = 30;
    localparam int FP_61_NS = 61;
    localparam int FP_122_NS = 122;
    localparam int FP_244_NS = 244;
    localparam int FP_488_NS = 488;

    localparam int FP_OPT = 0;
    localparam int FP_30 = 1;
    localparam int FP_61 = 2;
    localparam int FP_122 = 3;
    localparam int FP_244 = 4;
    localparam int FP_RX = 5;
    localparam int FP_TX = 6;
    localparam int FP_NUM = 7;
    localparam int FCNT_W = 16;

    localparam logic [FCNT_W-1:0] FP_CYCLES [FP_NUM] = '{
        FCNT_W'(CLK_HZ / OPT_HZ),
        FCNT_W'(FP_30_NS / CLK_PERIOD_NS),
        FCNT_W'(FP_61_NS / CLK_PERIOD_NS),
        FCNT_W'(FP_122_NS / CLK_PERIOD_NS),
        FCNT_W'(FP_244_NS / CLK_PERIOD_NS),
        FCNT_W'(FP_488_NS / CLK_PERIOD_NS),
        FCNT_W'(FP_488_NS / CLK_PERIOD_NS)
    };
    // 1 = active low
    localparam logic [FP_NUM-1:0] FP_ACT_LOW = 7'h16;

    ////////////////////////////////////////////////////////////////////////////
    // reference frequency select codes
    localparam logic [1:0] REF_SEL_19M44 = 2'h0;
    localparam logic [1:0] REF_SEL_8K = 2'h1;
    localparam logic [1:0] REF_SEL_1M544 = 2'h2;
    localparam logic [1:0] REF_SEL_2M048 = 2'h3;

endpackage

//--- sim/tcf_chk.sv
// frame pulse shape checks for the clock and frame output stage
`timescale 1ns/1ps
module tcf_chk (
    input wire logic clock,
    input wire logic rstn,
    input wire logic optical_frame_out,
    input wire logic frame_pulse_30ns_n,
    input wire logic frame_pulse_61ns_n,
    input wire logic frame_pulse_122ns,
    input wire logic frame_pulse_244ns_n,
    input wire logic receive_sync_pulse,
    input wire logic transmit_sync_pulse
);
    default clocking @(posedge clock); endclocking
    default disable iff (!rstn);
    // 122 ns pulse is the frame marker every other pulse is timed from
    sequence fs;
        $rose(frame_pulse_122ns);
    endsequence
    a_start_align: assert property (fs |-> !frame_pulse_30ns_n && !frame_pulse_61ns_n
        && !frame_pulse_244ns_n && optical_frame_out && receive_sync_pulse)
        else $error("pulses not aligned");
    a_f30_end: assert property (fs |-> ##6 $rose(frame_pulse_30ns_n))
        else $error("f30 width");
    a_f61_end: assert property (fs |-> ##12 $rose(frame_pulse_61ns_n))
        else $error("f61 width");
    a_f122_end: assert property (fs |-> ##24 $fell(frame_pulse_122ns))
        else $error("f122 width");
    a_f244_end: assert property (fs |-> ##48 $rose(frame_pulse_244ns_n))
        else $error("f244 width");
    a_sync_end: assert property (fs |-> ##97 $fell(receive_sync_pulse))
        else $error("sync width");
    a_sync_pair: assert property (receive_sync_pulse == transmit_sync_pulse)
        else $error("sync pair");
    a_opt_end: assert property (fs |-> ##10 $fell(optical_frame_out))
        else $error("optical width");
    cover property (fs);
    cover property ($fell(receive_sync_pulse));
    cover property ($rose(frame_pulse_244ns_n));
endmodule
bind tcf_outputs tcf_chk u_chk (.clock, .rstn, .optical_frame_out, .frame_pulse_30ns_n,
    .frame_pulse_61ns_n, .frame_pulse_122ns, .frame_pulse_244ns_n, .receive_sync_pulse,
    .transmit_sync_pulse);

//--- sim/tcf_framer_model.sv
// downstream framer that opens a frame on the 244 ns pulse
`timescale 1ns/1ps
module tcf_framer_model (
    input wire logic clock,
    input wire logic rstn,
    input wire logic frame_pulse_244ns_n,
    output logic frame_start
);
    logic pulse_q;
    // only the asserted edge counts, a held level is no new frame
    assign frame_start = pulse_q && !frame_pulse_244ns_n;
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) pulse_q <= 1'b1;
        else pulse_q <= frame_pulse_244ns_n;
    end
endmodule

//--- sim/tb_top.sv
// self-checking bench for the clock and frame output stage
`timescale 1ns/1ps
module tb_top;
    import tcf_pkg::*;
    // short frame keeps the run small, rates still resolve to one edge
    localparam int FL = 2000;
    logic clock = 1'b0;
    logic rstn = 1'b0;
    logic ref_select = 1'b0;
    logic [3:0] fsel = 4'h0;
    logic [1:0] ref_in = 2'h0;
    logic sel_ref, f244_n, frame_start;
    logic [7:0] clk_o;
    integer seed = 28;
    int errors = 0;
    int samples_checked = 0;
    longint hz [8] = '{E1_HZ, T1X2_HZ, T1_HZ, DS2_HZ, BP_TOP_HZ, BP_HIGH_HZ, OPT_HZ, E1_HZ};
    tcf_outputs #(.FRAME_LEN(FL)) dut (.clock, .rstn, .ref_select,
        .ref_a_freq_sel(fsel[1:0]), .ref_b_freq_sel(fsel[3:2]), .reference_in_a(ref_in[0]),
        .reference_in_b(ref_in[1]), .selected_reference(sel_ref), .e1_clock_out(clk_o[0]),
        .t1_double_clock_out(clk_o[1]), .t1_clock_out(clk_o[2]), .ds2_clock_out(clk_o[3]),
        .backplane_clock_top(clk_o[4]), .backplane_clock_high(clk_o[5]),
        .optical_clock_out(clk_o[6]), .follow_ref_clock_out(clk_o[7]), .optical_frame_out(),
        .frame_pulse_30ns_n(), .frame_pulse_61ns_n(), .frame_pulse_122ns(),
        .frame_pulse_244ns_n(f244_n), .receive_sync_pulse(), .transmit_sync_pulse());
    tcf_framer_model fm (.clock, .rstn, .frame_pulse_244ns_n(f244_n), .frame_start);
    initial forever #2.5 clock = ~clock;
    always @(posedge clock) ref_in <= 2'($random(seed));
    task automatic chk(string name, logic [31:0] seen, logic [31:0] want);
        samples_checked++;
        if (seen !== want) begin
            errors++;
            $display("Error %s expected %0d seen %0d", name, want, seen);
        end
    endtask
    task automatic report_and_stop();
        if (errors == 0 && samples_checked > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    // rising edges a clock of rate f shows within one short frame
    function automatic int edges_per_frame(longint f);
        return int'(f * FL / CLK_HZ);
    endfunction
    // follow clock runs at t1 rate only for a 1.544 MHz reference
    function automatic longint follow_hz(logic [1:0] code);
        return (code == REF_SEL_1M544) ? T1_HZ : E1_HZ;
    endfunction
    initial begin
        int k, s, e, m;
        int n [8];
        logic [7:0] prev;
        logic [1:0] pin;
        repeat (6) @(posedge clock);
        rstn <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            @(posedge clock);
            if (i == 2) begin
                rstn <= 1'b0;
                repeat (3) @(posedge clock);
                rstn <= 1'b1;
            end
            // order picks every code on the chosen side, both sides used
            ref_select <= ^2'(i);
            fsel <= {2'(i), ~2'(i)};
            #1;
            hz[7] = follow_hz(fsel[{ref_select, 1'b0} +: 2]);
            for (k = 0; k < FL + 9 && frame_start !== 1'b1; k++) begin
                @(posedge clock);
                #1;
            end
            if (frame_start !== 1'b1) begin
                // no frame start within the bound is a failure, stop measuring
                errors++;
                break;
            end
            prev = clk_o;
            pin = ref_in;
            n = '{default: 0};
            for (k = 0; k < FL; k++) begin
                @(posedge clock);
                #1;
                chk("sel_ref", sel_ref, pin[ref_select]);
                for (s = 0; s < 8; s++) n[s] += clk_o[s] === 1'b1 && prev[s] === 1'b0;
                prev = clk_o;
                pin = ref_in;
            end
            chk("period", frame_start, 1);
            for (s = 0; s < 8; s++) begin
                // nco edges land on 5 ns steps, so allow one edge either way
                e = edges_per_frame(hz[s]);
                m = n[s] inside {[e - 1:e + 1]} ? e : n[s];
                chk($sformatf("rate%0d", s), m, e);
            end
        end
        report_and_stop();
    end
endmodule
